// File: dar_host_model.sv
// Purpose: host model, an AXI4-Lite master for the shared register group
// Assumes: the bench asks for one transfer at a time and waits for done_o
// Notes: a released address or write data shows its inverse (wstrb keeps its value) so stale values are never mistaken for live ones
`timescale 1ns/10ps

module dar_host_model
  import dar_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic [3:0] strb_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic [1:0] resp_o,
  output logic [ADDR_W-1:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [ADDR_W-1:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // each channel holds valid and payload until its own ready edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {awvalid_o, wvalid_o, arvalid_o, bready_o, rready_o, done_o} <= 6'h00;
      {awaddr_o, araddr_o, wstrb_o} <= '0;
      {wdata_o, rdata_o, resp_o} <= '0;
    end else begin
      done_o <= 1'b0;
      if (req_i && we_i) begin
        {awvalid_o, wvalid_o, bready_o} <= 3'h7;
        awaddr_o <= addr_i;
        wdata_o <= data_i;
        wstrb_o <= strb_i;
      end
      if (req_i && !we_i) begin
        {arvalid_o, rready_o} <= 2'h3;
        araddr_o <= addr_i;
      end
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~awaddr_o;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~wdata_o;
      end
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~araddr_o;
      end
      if (bready_o && bvalid_i) begin
        bready_o <= 1'b0;
        resp_o <= bresp_i;
        done_o <= 1'b1;
      end
      if (rready_o && rvalid_i) begin
        rready_o <= 1'b0;
        resp_o <= rresp_i;
        rdata_o <= rdata_i;
        done_o <= 1'b1;
      end
    end
  end
endmodule : dar_host_model

// File: dar_pkg.sv
// Purpose: constants for the shared register group, and the per-pin change detector
// Assumes: one 250 MHz clock, asynchronous active-low reset, pins synchronous to clk_i
// Notes: register map is word aligned, data in the low byte, upper bits read zero
// Functional notes
// - aux_control bit 7 picks baud generator rate group, zero first, one second.
// - aux_control bits 3..0 enable input pins 3..0 toward port-change interrupt.
// - input_change_status bits 7..4 flag changes seen on input pins 3..0.
// - input_change_status bits 3..0 return present levels of input pins 3..0.
// - interrupt_status bits 7..4: port change, break B, receive B, transmit B.
// - interrupt_status bits 3..0: counter ready, break A, receive A, transmit A.
// - one mask bit per status bit; one enables, zero disables that interrupt.
// - counter_preset_high holds preset bits 15..8, bit 7 is preset bit 15.
// - counter_preset_low holds preset bits 7..0, bit 7 is preset bit 7.
// - interrupt_vector stores eight vector bits, register bit n is vector bit n.
// - output_bit_set_strobe write sets latch bits written one, others unchanged.
// - output_bit_clear_strobe write clears latch bits written one, others unchanged.
// - each output pin is the inverse of its output_port_latch bit.
// - per channel, receive interrupt source is ready or full per select mode bit.
`timescale 1ns/10ps

package dar_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] AUX_CONTROL_ADDR = 6'h00;
  localparam logic [ADDR_W-1:0] INPUT_CHANGE_STATUS_ADDR = 6'h04;
  localparam logic [ADDR_W-1:0] INTERRUPT_STATUS_ADDR = 6'h08;
  localparam logic [ADDR_W-1:0] INTERRUPT_MASK_ADDR = 6'h0C;
  localparam logic [ADDR_W-1:0] COUNTER_PRESET_HIGH_ADDR = 6'h10;
  localparam logic [ADDR_W-1:0] COUNTER_PRESET_LOW_ADDR = 6'h14;
  localparam logic [ADDR_W-1:0] INTERRUPT_VECTOR_ADDR = 6'h18;
  localparam logic [ADDR_W-1:0] OUTPUT_BIT_SET_STROBE_ADDR = 6'h1C;
  localparam logic [ADDR_W-1:0] OUTPUT_BIT_CLEAR_STROBE_ADDR = 6'h20;
  localparam logic [ADDR_W-1:0] OUTPUT_PORT_LATCH_ADDR = 6'h24;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int AUX_BAUD_SET_BIT = 7;
  localparam int AUX_CT_MODE_HI = 6;
  localparam int AUX_CT_MODE_LO = 4;
  localparam int AUX_DELTA_EN_HI = 3;
  localparam int IPCS_DELTA_LO = 4;
  localparam int ISR_PORT_CHANGE = 7;
  localparam int ISR_BREAK_B = 6;
  localparam int ISR_RX_B = 5;
  localparam int ISR_TX_B = 4;
  localparam int ISR_COUNTER = 3;
  localparam int ISR_BREAK_A = 2;
  localparam int ISR_RX_A = 1;
  localparam int ISR_TX_A = 0;
  localparam int CHAN_A = 0;
  localparam int CHAN_B = 1;
  localparam int NUM_PINS = 4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] OUT_PINS_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dar_pkg

// ****************************************************************
// one input pin: remembers last level, flags a change until read
// ****************************************************************
module dar_pin_delta (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic arm_i,
  input wire logic pin_i,
  input wire logic clear_i,
  output logic delta_o
);
  logic last_level;
  wire changed = arm_i && (pin_i != last_level);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_level <= 1'b0;
      delta_o <= 1'b0;
    end else begin
      last_level <= pin_i;
      // a change seen in the clearing cycle is kept
      if (changed) begin
        delta_o <= 1'b1;
      end else if (clear_i) begin
        delta_o <= 1'b0;
      end
    end
  end
endmodule : dar_pin_delta

// File: dar_regs.sv
// Purpose: shared register group with AXI4-Lite slave, interrupt logic and output port latch
// Assumes: single clock, AXI4-Lite master keeps one write and one read outstanding at most
// Notes: only byte lane 0 carries register data; unmapped addresses answer SLVERR
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps

module dar_regs
  import dar_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_PINS-1:0] input_pins_i,
  input wire logic chan_a_transmit_ready_i,
  input wire logic chan_b_transmit_ready_i,
  input wire logic [1:0] receiver_ready_i,
  input wire logic [1:0] receive_buffer_full_i,
  input wire logic [1:0] rx_int_select_i,
  input wire logic [1:0] break_change_i,
  input wire logic counter_ready_i,
  output logic [7:0] out_pins_o,
  output logic baud_set_o,
  output logic [2:0] ct_mode_o,
  output logic [15:0] ct_preset_o,
  output logic [7:0] interrupt_vector_o,
  output logic irq_o
);
  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] aux_control;
  logic [7:0] interrupt_status;
  logic [7:0] interrupt_mask;
  logic [7:0] counter_preset_high;
  logic [7:0] counter_preset_low;
  logic [7:0] interrupt_vector;
  logic [7:0] output_port_latch;
  logic [NUM_PINS-1:0] pin_delta;
  logic armed;

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] waddr;
  logic [7:0] wdata;
  logic wlane;

  wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
  wire b_fire = s_axi_bvalid_o && s_axi_bready_i;
  wire wr_go = aw_held && w_held && !s_axi_bvalid_o;
  wire wr_en = wr_go && wlane;

  wire wr_aux = wr_en && (waddr == AUX_CONTROL_ADDR);
  wire wr_isr = wr_en && (waddr == INTERRUPT_STATUS_ADDR);
  wire wr_mask = wr_en && (waddr == INTERRUPT_MASK_ADDR);
  wire wr_cth = wr_en && (waddr == COUNTER_PRESET_HIGH_ADDR);
  wire wr_ctl = wr_en && (waddr == COUNTER_PRESET_LOW_ADDR);
  wire wr_vec = wr_en && (waddr == INTERRUPT_VECTOR_ADDR);
  wire wr_set = wr_en && (waddr == OUTPUT_BIT_SET_STROBE_ADDR);
  wire wr_clr = wr_en && (waddr == OUTPUT_BIT_CLEAR_STROBE_ADDR);
  wire w_mapped = (waddr == AUX_CONTROL_ADDR) || (waddr == INTERRUPT_STATUS_ADDR) ||
                  (waddr == INTERRUPT_MASK_ADDR) || (waddr == COUNTER_PRESET_HIGH_ADDR) ||
                  (waddr == COUNTER_PRESET_LOW_ADDR) || (waddr == INTERRUPT_VECTOR_ADDR) ||
                  (waddr == OUTPUT_BIT_SET_STROBE_ADDR) || (waddr == OUTPUT_BIT_CLEAR_STROBE_ADDR);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wdata <= REG_RST;
      wlane <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        waddr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        wdata <= s_axi_wdata_i[7:0];
        wlane <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_fire) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire r_fire = s_axi_rvalid_o && s_axi_rready_i;
  wire rd_ipcs = ar_fire && (s_axi_araddr_i == INPUT_CHANGE_STATUS_ADDR);
  wire [7:0] ipcs_view = {pin_delta, input_pins_i};
  logic [7:0] rd_byte;
  logic rd_mapped;

  always_comb begin
    rd_byte = REG_RST;
    rd_mapped = 1'b1;
    case (s_axi_araddr_i)
      AUX_CONTROL_ADDR: rd_byte = aux_control;
      INPUT_CHANGE_STATUS_ADDR: rd_byte = ipcs_view;
      INTERRUPT_STATUS_ADDR: rd_byte = interrupt_status;
      INTERRUPT_MASK_ADDR: rd_byte = interrupt_mask;
      COUNTER_PRESET_HIGH_ADDR: rd_byte = counter_preset_high;
      COUNTER_PRESET_LOW_ADDR: rd_byte = counter_preset_low;
      INTERRUPT_VECTOR_ADDR: rd_byte = interrupt_vector;
      OUTPUT_BIT_SET_STROBE_ADDR: rd_byte = REG_RST;
      OUTPUT_BIT_CLEAR_STROBE_ADDR: rd_byte = REG_RST;
      OUTPUT_PORT_LATCH_ADDR: rd_byte = output_port_latch;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h000000, rd_byte};
        s_axi_rresp_o <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (r_fire) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // input pin change detection
  // ****************************************************************
  // the first edge after reset only loads the last level, so a pin
  // strapped high does not look like a change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    dar_pin_delta u_delta (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .arm_i(armed),
      .pin_i(input_pins_i[i]),
      .clear_i(rd_ipcs),
      .delta_o(pin_delta[i])
    );
  end

  // ****************************************************************
  // interrupt status, mask and request
  // ****************************************************************
  wire [NUM_PINS-1:0] delta_en = aux_control[AUX_DELTA_EN_HI:0];
  wire rx_src_a = rx_int_select_i[CHAN_A] ? receive_buffer_full_i[CHAN_A] : receiver_ready_i[CHAN_A];
  wire rx_src_b = rx_int_select_i[CHAN_B] ? receive_buffer_full_i[CHAN_B] : receiver_ready_i[CHAN_B];
  logic [7:0] isr_src;
  always_comb begin
    isr_src = REG_RST;
    isr_src[ISR_PORT_CHANGE] = |(pin_delta & delta_en);
    isr_src[ISR_BREAK_B] = break_change_i[CHAN_B];
    isr_src[ISR_RX_B] = rx_src_b;
    isr_src[ISR_TX_B] = chan_b_transmit_ready_i;
    isr_src[ISR_COUNTER] = counter_ready_i;
    isr_src[ISR_BREAK_A] = break_change_i[CHAN_A];
    isr_src[ISR_RX_A] = rx_src_a;
    isr_src[ISR_TX_A] = chan_a_transmit_ready_i;
  end
  // sticky with write-one-to-clear; a source still high re-sets at once
  wire [7:0] isr_clear = wr_isr ? wdata : REG_RST;
  wire [7:0] next_interrupt_status = (interrupt_status & ~isr_clear) | isr_src;
  wire next_irq = |(interrupt_status & interrupt_mask);

  // ****************************************************************
  // software registers and output port latch
  // ****************************************************************
  logic [7:0] next_output_port_latch;
  always_comb begin
    next_output_port_latch = output_port_latch;
    if (wr_set) begin
      next_output_port_latch = output_port_latch | wdata;
    end else if (wr_clr) begin
      next_output_port_latch = output_port_latch & ~wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_control <= REG_RST;
      interrupt_status <= REG_RST;
      interrupt_mask <= REG_RST;
      counter_preset_high <= REG_RST;
      counter_preset_low <= REG_RST;
      interrupt_vector <= REG_RST;
      output_port_latch <= REG_RST;
      out_pins_o <= OUT_PINS_RST;
      irq_o <= 1'b0;
    end else begin
      if (wr_aux) aux_control <= wdata;
      if (wr_mask) interrupt_mask <= wdata;
      if (wr_cth) counter_preset_high <= wdata;
      if (wr_ctl) counter_preset_low <= wdata;
      if (wr_vec) interrupt_vector <= wdata;
      interrupt_status <= next_interrupt_status;
      output_port_latch <= next_output_port_latch;
      out_pins_o <= ~next_output_port_latch;
      irq_o <= next_irq;
    end
  end

  // direct flop outputs
  assign baud_set_o = aux_control[AUX_BAUD_SET_BIT];
  assign ct_mode_o = aux_control[AUX_CT_MODE_HI:AUX_CT_MODE_LO];
  assign ct_preset_o = {counter_preset_high, counter_preset_low};
  assign interrupt_vector_o = interrupt_vector;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_baud_set;
    wr_aux |=> baud_set_o == $past(wdata[AUX_BAUD_SET_BIT]);
  endproperty
  a_baud_set: assert property (p_baud_set) else $error("baud group not taken from aux bit 7");

  property p_delta_int;
    (armed && delta_en[0] && pin_delta[0]) |=> interrupt_status[ISR_PORT_CHANGE];
  endproperty
  a_delta_int: assert property (p_delta_int) else $error("enabled pin change did not flag port change");

  property p_pin_change;
    (armed && $past(armed) && input_pins_i[1] != $past(input_pins_i[1])) |=> pin_delta[1];
  endproperty
  a_pin_change: assert property (p_pin_change) else $error("pin change not recorded");

  property p_pin_level;
    (rd_ipcs) |=> s_axi_rdata_o[3:0] == $past(input_pins_i);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin levels misread");

  property p_isr_upper;
    chan_b_transmit_ready_i && break_change_i[CHAN_B] |=> interrupt_status[ISR_TX_B] && interrupt_status[ISR_BREAK_B];
  endproperty
  a_isr_upper: assert property (p_isr_upper) else $error("channel B status not flagged");

  property p_isr_lower;
    counter_ready_i && chan_a_transmit_ready_i |=> interrupt_status[ISR_COUNTER] && interrupt_status[ISR_TX_A];
  endproperty
  a_isr_lower: assert property (p_isr_lower) else $error("counter or channel A status not flagged");

  property p_mask_off;
    (interrupt_mask == REG_RST) [*2] |=> !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt raised while fully masked");

  property p_preset;
    wr_cth |=> ct_preset_o[15:8] == $past(wdata);
  endproperty
  a_preset: assert property (p_preset) else $error("counter preset halves misplaced");

  property p_vector;
    wr_vec |=> interrupt_vector_o == $past(wdata);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not stored");

  property p_set_strobe;
    wr_set |=> output_port_latch == ($past(output_port_latch) | $past(wdata));
  endproperty
  a_set_strobe: assert property (p_set_strobe) else $error("set strobe wrong");

  property p_clr_strobe;
    wr_clr |=> output_port_latch == ($past(output_port_latch) & ~$past(wdata));
  endproperty
  a_clr_strobe: assert property (p_clr_strobe) else $error("clear strobe wrong");

  property p_pin_invert;
    out_pins_o == ~output_port_latch;
  endproperty
  a_pin_invert: assert property (p_pin_invert) else $error("output pins not inverted latch");

  property p_rx_select;
    rx_int_select_i[CHAN_A] && receive_buffer_full_i[CHAN_A] |=> interrupt_status[ISR_RX_A];
  endproperty
  a_rx_select: assert property (p_rx_select) else $error("full select ignored");

  property p_irq;
    |(interrupt_status & interrupt_mask) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked status without request");

  property p_ct_mode;
    wr_aux |=> ct_mode_o == $past(wdata[AUX_CT_MODE_HI:AUX_CT_MODE_LO]);
  endproperty
  a_ct_mode: assert property (p_ct_mode) else $error("counter mode field not passed");

  property p_write_answer;
    aw_fire && w_fire |=> ##[0:1] s_axi_bvalid_o;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");

  c_irq: cover property (wr_mask ##[1:20] irq_o);
  c_pin_read: cover property (pin_delta[0] ##1 rd_ipcs);
  c_set_clear: cover property (wr_set ##[1:20] wr_clr);
  c_unmapped: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
endmodule : dar_regs

// File: duart_aux_int_port_regs_tb.sv
// Purpose: self-checking bench for the shared register group
// Assumes: sources pulse for one cycle so sticky status can be cleared afterwards
// Notes: expectations come from bench models of the latch, pins and status layout
`timescale 1ns/10ps

module duart_aux_int_port_regs_tb
  import dar_pkg::*;
  ;
  logic clk_i, rst_n_i, req, we, done, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, baud, irq;
  logic [ADDR_W-1:0] addr, awaddr, araddr;
  logic [31:0] data, rdata, wdata, h_rdata;
  logic [3:0] strb, wstrb, pins, old, np;
  logic [1:0] resp, bresp, rresp, rx_sel, fsrc;
  logic [6:0] src;
  logic [7:0] out_pins, ivec, lat, v;
  logic [2:0] ct_mode;
  logic [15:0] preset;
  logic [ADDR_W-1:0] rst_addr [6] = '{6'h00, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h24};
  int errors, checks_done;

  dar_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .we_i(we), .addr_i(addr),
    .data_i(data), .strb_i(strb), .done_o(done), .rdata_o(h_rdata), .resp_o(resp), .awaddr_o(awaddr),
    .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
    .rready_o(rready));

  dar_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .input_pins_i(pins), .chan_a_transmit_ready_i(src[0]), .chan_b_transmit_ready_i(src[4]),
    .receiver_ready_i({src[5], src[1]}), .receive_buffer_full_i(fsrc), .rx_int_select_i(rx_sel),
    .break_change_i({src[6], src[2]}), .counter_ready_i(src[3]), .out_pins_o(out_pins),
    .baud_set_o(baud), .ct_mode_o(ct_mode), .ct_preset_o(preset), .interrupt_vector_o(ivec),
    .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [7:0] bitv(input int b);
    return 8'h01 << b;
  endfunction : bitv

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    addr <= a;
    data <= d;
    strb <= s;
    @(posedge clk_i);
    req <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) errors++;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
    bus(1'b0, a, 32'h0, 4'h0);
    chk({30'h0, resp}, {30'h0, er});
    chk(h_rdata, {24'h0, e});
  endtask : rd

  // one-cycle pulse; full picks the buffer-full source of a receive bit
  task automatic pulse(input int b, input logic full);
    @(posedge clk_i);
    if (full) fsrc <= (b == 1) ? 2'b01 : 2'b10;
    else src <= 7'(bitv(b));
    @(posedge clk_i);
    src <= 7'h00;
    fsrc <= 2'b00;
    repeat (4) @(posedge clk_i);
  endtask : pulse

  task automatic setpins(input logic [3:0] n);
    @(posedge clk_i);
    pins <= n;
    repeat (6) @(posedge clk_i);
  endtask : setpins

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {errors, checks_done} = '0;
    {req, we, addr, data, strb, pins, old, src, fsrc, rx_sel, lat} = '0;
    rst_n_i = 1'b0;
    void'($urandom(32'h36704009));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({24'h0, out_pins}, 32'hFF);
    chk({31'h0, irq}, 32'h0);
    foreach (rst_addr[i]) rd(rst_addr[i], 8'h00, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      wr(AUX_CONTROL_ADDR, v);
      chk({31'h0, baud}, {31'h0, v[7]});
      chk({29'h0, ct_mode}, {29'h0, v[6:4]});
      rd(AUX_CONTROL_ADDR, v, RESP_OKAY);
      wr(INTERRUPT_MASK_ADDR, ~v);
      rd(INTERRUPT_MASK_ADDR, ~v, RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(COUNTER_PRESET_HIGH_ADDR, v ^ 8'hA5);
      wr(COUNTER_PRESET_LOW_ADDR, ~v);
      chk({16'h0, preset}, {16'h0, v ^ 8'hA5, ~v});
      wr(INTERRUPT_VECTOR_ADDR, v + 8'h3C);
      chk({24'h0, ivec}, {24'h0, v + 8'h3C});
    end
    // strobe lane off must leave the vector alone
    bus(1'b1, INTERRUPT_VECTOR_ADDR, 32'hFF, 4'h0);
    rd(INTERRUPT_VECTOR_ADDR, v + 8'h3C, RESP_OKAY);
    rd(6'h28, 8'h00, RESP_SLVERR);
    wr(AUX_CONTROL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom());
      wr(OUTPUT_BIT_SET_STROBE_ADDR, v);
      lat = lat | v;
      chk({24'h0, out_pins}, {24'h0, ~lat});
      v = (i == 0) ? 8'h00 : 8'($urandom());
      wr(OUTPUT_BIT_CLEAR_STROBE_ADDR, v);
      lat = lat & ~v;
      chk({24'h0, out_pins}, {24'h0, ~lat});
      rd(OUTPUT_PORT_LATCH_ADDR, lat, RESP_OKAY);
    end
    for (int i = 0; i < 6; i++) begin
      np = (i == 0) ? 4'hF : 4'($urandom());
      setpins(np);
      rd(INPUT_CHANGE_STATUS_ADDR, {old ^ np, np}, RESP_OKAY);
      old = np;
    end
    wr(INTERRUPT_STATUS_ADDR, 8'hFF);
    for (int b = 0; b < 7; b++) begin
      wr(INTERRUPT_MASK_ADDR, bitv(b));
      pulse(b, 1'b0);
      chk({31'h0, irq}, 32'h1);
      rd(INTERRUPT_STATUS_ADDR, bitv(b), RESP_OKAY);
      wr(INTERRUPT_STATUS_ADDR, bitv(b));
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
    end
    // masked source: status still records, request stays low
    wr(INTERRUPT_MASK_ADDR, 8'hF7);
    pulse(3, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(INTERRUPT_STATUS_ADDR, 8'h08, RESP_OKAY);
    wr(INTERRUPT_STATUS_ADDR, 8'h08);
    rx_sel <= 2'b11;
    pulse(1, 1'b0);
    pulse(5, 1'b0);
    rd(INTERRUPT_STATUS_ADDR, 8'h00, RESP_OKAY);
    pulse(1, 1'b1);
    pulse(5, 1'b1);
    rd(INTERRUPT_STATUS_ADDR, 8'h22, RESP_OKAY);
    wr(INTERRUPT_STATUS_ADDR, 8'h22);
    wr(AUX_CONTROL_ADDR, 8'h01);
    wr(INTERRUPT_MASK_ADDR, 8'h80);
    np = old ^ 4'h8;
    setpins(np);
    chk({31'h0, irq}, 32'h0);
    rd(INPUT_CHANGE_STATUS_ADDR, {4'h8, np}, RESP_OKAY);
    old = np;
    np = old ^ 4'h1;
    setpins(np);
    chk({31'h0, irq}, 32'h1);
    rd(INTERRUPT_STATUS_ADDR, 8'h80, RESP_OKAY);
    rd(INPUT_CHANGE_STATUS_ADDR, {4'h1, np}, RESP_OKAY);
    wr(INTERRUPT_STATUS_ADDR, 8'h80);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    print_verdict();
  end

  // cut a hang well beyond the fewer than one thousand cycles the scenarios need
  initial begin
    repeat (50000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
endmodule : duart_aux_int_port_regs_tb
